/* File: core/sad_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module sad_decoder import sad_pkg::*; (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic [SAD_AW-1:0] req_addr,
    input wire logic [2:0] req_size,
    input wire logic req_write,
    input wire logic [1:0] boot_sel,
    input wire logic sram_cfg_8k,
    output logic dec_valid_reg,
    output logic [SAD_NSEL-1:0] sel_reg,
    output logic [SAD_WINW-1:0] win_reg,
    output logic wr_en_reg,
    output logic zero_rdata_reg,
    output logic err_resp_reg,
    output logic hard_fault_reg
);
    logic [SAD_NREG-1:0] hit;
    logic width_ok;
    logic sram_small_reg, sram_small_next;
    logic cfg_taken_reg, cfg_taken_next;
    logic dec_valid_next, wr_en_next, zero_rdata_next;
    logic err_resp_next, hard_fault_next;
    logic [SAD_NSEL-1:0] sel_next;
    logic [SAD_WINW-1:0] win_next;
    logic [SAD_WINW-1:0] pbus_idx, hbus_idx, iop_idx;
    logic sram_hit, win_hit, is_crc, is_pwr, mapped;

    sad_region_match #(.NREG(SAD_NREG)) u_match (
        .addr(req_addr),
        .hit(hit)
    );

    assign pbus_idx = req_addr[SAD_PBUS_MSB:SAD_WIN_LSB];
    assign hbus_idx = {3'h0, req_addr[SAD_HBUS_MSB:SAD_WIN_LSB]};
    assign iop_idx = {4'h0, req_addr[SAD_IOP_MSB:SAD_WIN_LSB]};
    assign is_crc = hit[SAD_R_HBUS] && (hbus_idx == SAD_WIN_CLOCK_RESET_CTRL);
    assign is_pwr = hit[SAD_R_PBUS] && (pbus_idx == SAD_WIN_POWER_CTRL);

    sad_width_check u_width (
        .size(req_size),
        .in_clock_reset_ctrl(is_crc),
        .in_power_ctrl(is_pwr),
        .width_ok(width_ok)
    );

    // Size strap is caught after reset release, never under reset
    always_comb begin
        cfg_taken_next = 1'b1;
        sram_small_next = cfg_taken_reg ? sram_small_reg : sram_cfg_8k;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg_taken_reg <= 1'b0;
            sram_small_reg <= 1'b0;
        end else begin
            cfg_taken_reg <= cfg_taken_next;
            sram_small_reg <= sram_small_next;
        end
    end

    // SRAM top moves down with the strap
    assign sram_hit = hit[SAD_R_SRAM] &&
        (!sram_small_reg || req_addr <= SAD_SRAM_SMALL_LIMIT);

    always_comb begin
        sel_next = '0;
        win_next = '0;
        win_hit = 1'b0;
        if (hit[SAD_R_ALIAS]) begin
            if (boot_sel == SAD_BOOT_SYSMEM) begin
                sel_next[SAD_S_SYSMEM] = 1'b1;
            end else if (boot_sel == SAD_BOOT_SRAM) begin
                sel_next[SAD_S_SRAM] = 1'b1;
            end else begin
                sel_next[SAD_S_FLASH] = 1'b1;
            end
        end else if (hit[SAD_R_FLASH]) begin
            sel_next[SAD_S_FLASH] = 1'b1;
        end else if (hit[SAD_R_SYSMEM]) begin
            sel_next[SAD_S_SYSMEM] = 1'b1;
        end else if (hit[SAD_R_UID]) begin
            sel_next[SAD_S_UID] = 1'b1;
        end else if (hit[SAD_R_OPTION]) begin
            sel_next[SAD_S_OPTION] = 1'b1;
        end else if (hit[SAD_R_FACTORY]) begin
            sel_next[SAD_S_FACTORY] = 1'b1;
        end else if (sram_hit) begin
            sel_next[SAD_S_SRAM] = 1'b1;
        end else if (hit[SAD_R_PBUS]) begin
            win_hit = SAD_PBUS_MAP[pbus_idx];
            sel_next[SAD_S_PBUS] = win_hit;
            win_next = pbus_idx;
        end else if (hit[SAD_R_HBUS]) begin
            win_hit = SAD_HBUS_MAP[hbus_idx[3:0]];
            sel_next[SAD_S_HBUS] = win_hit;
            win_next = hbus_idx;
        end else if (hit[SAD_R_IOP]) begin
            win_hit = SAD_IOP_MAP[iop_idx[2:0]];
            sel_next[SAD_S_IOP] = win_hit;
            win_next = iop_idx;
        end else if (hit[SAD_R_CORE]) begin
            sel_next[SAD_S_CORE] = 1'b1;
        end
        // A width the target refuses turns the access into an error
        if (!width_ok || !req_valid) begin
            sel_next = '0;
        end
        if (sel_next == '0) begin
            win_next = '0;
        end
    end

    // Error path only when no select fires
    always_comb begin
        dec_valid_next = req_valid;
        mapped = (sel_next != '0);
        err_resp_next = req_valid && !mapped;
        hard_fault_next = req_valid && !mapped &&
            (req_addr >= SAD_PERIPH_SPACE);
        zero_rdata_next = err_resp_next && !req_write;
        wr_en_next = req_valid && req_write && mapped;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            dec_valid_reg <= 1'b0;
            sel_reg <= '0;
            win_reg <= '0;
            wr_en_reg <= 1'b0;
            zero_rdata_reg <= 1'b0;
            err_resp_reg <= 1'b0;
            hard_fault_reg <= 1'b0;
        end else begin
            dec_valid_reg <= dec_valid_next;
            sel_reg <= sel_next;
            win_reg <= win_next;
            wr_en_reg <= wr_en_next;
            zero_rdata_reg <= zero_rdata_next;
            err_resp_reg <= err_resp_next;
            hard_fault_reg <= hard_fault_next;
        end
    end

    // Checks: all decisions appear one edge after the request
    sequence s_req_at(logic [SAD_AW-1:0] lo, logic [SAD_AW-1:0] hi);
        req_valid && req_addr >= lo && req_addr <= hi;
    endsequence

    sequence s_reserved_pbus;
        req_valid && hit[SAD_R_PBUS] && !SAD_PBUS_MAP[pbus_idx];
    endsequence

    property p_one_select;
        @(posedge clk_sys) disable iff (!rst_b)
        dec_valid_reg |-> ($onehot(sel_reg) != err_resp_reg);
    endproperty

    sequence s_req_ok_at(logic [SAD_AW-1:0] lo, logic [SAD_AW-1:0] hi);
        s_req_at(lo, hi) ##0 width_ok;
    endsequence

    unmapped_error_a: assert property (p_one_select)
        else $error("select and error not exclusive");

    reserved_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        err_resp_reg
        |-> !wr_en_reg && (zero_rdata_reg != $past(req_write)))
        else $error("reserved access not neutralised");

    pbus_fault_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_reserved_pbus
        |=> err_resp_reg && hard_fault_reg)
        else $error("reserved peripheral window did not fault");

    alias_route_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h0000_0000, 32'h0001_FFFF) ##0
        (boot_sel == SAD_BOOT_SRAM)
        |=> sel_reg[SAD_S_SRAM] && !err_resp_reg)
        else $error("alias did not follow boot selection");

    sram_small_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_at(32'h2000_2000, 32'h2000_3FFF) ##0 sram_small_reg
        |=> err_resp_reg && !sel_reg[SAD_S_SRAM])
        else $error("upper SRAM decoded in 8 KB mode");

    sram_low_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h2000_0000, 32'h2000_1FFF)
        |=> sel_reg[SAD_S_SRAM] && !err_resp_reg)
        else $error("lower SRAM missed");

    sysmem_span_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h1FFF_0000, 32'h1FFF_2FFF)
        |=> sel_reg[SAD_S_SYSMEM])
        else $error("system memory missed");

    option_area_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h1FFF_3080, 32'h1FFF_30FF)
        |=> sel_reg[SAD_S_OPTION] && !sel_reg[SAD_S_UID])
        else $error("option area missed");

    uid_area_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h1FFF_3000, 32'h1FFF_307F)
        |=> sel_reg[SAD_S_UID] && !sel_reg[SAD_S_OPTION])
        else $error("unique ID area missed");

    crc_byte_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        req_valid && is_crc && req_size == SAD_SIZE_BYTE
        |=> sel_reg[SAD_S_HBUS] && win_reg == SAD_WIN_CLOCK_RESET_CTRL)
        else $error("byte access to clock control refused");

    pwr_byte_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        req_valid && is_pwr && req_size == SAD_SIZE_BYTE
        |=> err_resp_reg && !sel_reg[SAD_S_PBUS] && !wr_en_reg)
        else $error("byte access to power control accepted");

    port_f_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h5000_1400, 32'h5000_17FF)
        |=> sel_reg[SAD_S_IOP] && win_reg == SAD_WIN_IO_PORT_F)
        else $error("port F window missed");

    port_a_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h5000_0000, 32'h5000_03FF)
        |=> sel_reg[SAD_S_IOP] && win_reg == SAD_WIN_IO_PORT_A)
        else $error("port A window missed");

    iop_gap_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_at(32'h5000_0C00, 32'h5000_13FF)
        |=> err_resp_reg && hard_fault_reg)
        else $error("I/O port gap not faulted");

    hbus_gap_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_at(32'h4002_0400, 32'h4002_0FFF)
        |=> hard_fault_reg)
        else $error("high-speed gap not faulted");

    hbus_dma_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h4002_0000, 32'h4002_03FF)
        |=> sel_reg[SAD_S_HBUS] && win_reg == '0)
        else $error("DMA window missed");

    pbus_timer_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_ok_at(32'h4000_0000, 32'h4000_03FF)
        |=> sel_reg[SAD_S_PBUS] && win_reg == '0)
        else $error("timer two window missed");

    fault_err_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        hard_fault_reg |-> err_resp_reg)
        else $error("hard fault without error response");

    zero_read_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        zero_rdata_reg |-> err_resp_reg && dec_valid_reg)
        else $error("zero read data outside an error");

    mem_gap_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_req_at(32'h0002_0000, 32'h07FF_FFFF)
        |=> err_resp_reg && !hard_fault_reg && sel_reg == '0)
        else $error("memory gap not refused");

    size_refuse_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        req_valid && req_size > SAD_SIZE_WORD
        |=> err_resp_reg && sel_reg == '0)
        else $error("oversized access accepted");

    idle_quiet_a: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !dec_valid_reg
        |-> sel_reg == '0 && !err_resp_reg && !wr_en_reg)
        else $error("outputs active without a request");

endmodule // sad_decoder
`default_nettype wire

/* File: core/sad_pkg.sv */
package sad_pkg;

    localparam int SAD_AW = 32;
    localparam int SAD_NREG = 11;
    localparam int SAD_NSEL = 10;
    localparam int SAD_WINW = 7;

    // Region indices into the boundary tables
    localparam int SAD_R_ALIAS = 0;
    localparam int SAD_R_FLASH = 1;
    localparam int SAD_R_SYSMEM = 2;
    localparam int SAD_R_UID = 3;
    localparam int SAD_R_OPTION = 4;
    localparam int SAD_R_FACTORY = 5;
    localparam int SAD_R_SRAM = 6;
    localparam int SAD_R_PBUS = 7;
    localparam int SAD_R_HBUS = 8;
    localparam int SAD_R_IOP = 9;
    localparam int SAD_R_CORE = 10;

    // Select bit positions; alias has no select of its own
    localparam int SAD_S_FLASH = 0;
    localparam int SAD_S_SYSMEM = 1;
    localparam int SAD_S_UID = 2;
    localparam int SAD_S_OPTION = 3;
    localparam int SAD_S_FACTORY = 4;
    localparam int SAD_S_SRAM = 5;
    localparam int SAD_S_PBUS = 6;
    localparam int SAD_S_HBUS = 7;
    localparam int SAD_S_IOP = 8;
    localparam int SAD_S_CORE = 9;

    localparam logic [SAD_AW-1:0] SAD_BASE [SAD_NREG] = '{
        32'h0000_0000, 32'h0800_0000, 32'h1FFF_0000, 32'h1FFF_3000,
        32'h1FFF_3080, 32'h1FFF_3100, 32'h2000_0000, 32'h4000_0000,
        32'h4002_0000, 32'h5000_0000, 32'hE000_0000};
    localparam logic [SAD_AW-1:0] SAD_LIMIT [SAD_NREG] = '{
        32'h0001_FFFF, 32'h0801_FFFF, 32'h1FFF_2FFF, 32'h1FFF_307F,
        32'h1FFF_30FF, 32'h1FFF_33FF, 32'h2000_3FFF, 32'h4001_FFFF,
        32'h4002_3BFF, 32'h5000_17FF, 32'hE00F_FFFF};

    // Upper end of SRAM when power-on configuration picks 8 KB
    localparam logic [SAD_AW-1:0] SAD_SRAM_SMALL_LIMIT = 32'h2000_1FFF;
    localparam logic [SAD_AW-1:0] SAD_PERIPH_SPACE = 32'h4000_0000;

    // 1 KB window index fields
    localparam int SAD_WIN_LSB = 10;
    localparam int SAD_PBUS_MSB = 16;
    localparam int SAD_HBUS_MSB = 13;
    localparam int SAD_IOP_MSB = 12;

    // Populated windows, one bit per 1 KB window
    localparam logic [127:0] SAD_PBUS_MAP =
        128'h0000_0000_0047_5A01_0000_0000_B9EE_5F33;
    localparam logic [15:0] SAD_HBUS_MAP = 16'h5151;
    localparam logic [7:0] SAD_IOP_MAP = 8'h27;

    localparam logic [SAD_WINW-1:0] SAD_WIN_CLOCK_RESET_CTRL = 7'h04;
    localparam logic [SAD_WINW-1:0] SAD_WIN_POWER_CTRL = 7'h1C;
    localparam logic [SAD_WINW-1:0] SAD_WIN_IO_PORT_A = 7'h00;
    localparam logic [SAD_WINW-1:0] SAD_WIN_IO_PORT_F = 7'h05;

    // Boot configuration codes for the alias at address zero
    localparam logic [1:0] SAD_BOOT_FLASH = 2'h0;
    localparam logic [1:0] SAD_BOOT_SYSMEM = 2'h1;
    localparam logic [1:0] SAD_BOOT_SRAM = 2'h2;

    localparam logic [2:0] SAD_SIZE_BYTE = 3'h0;
    localparam logic [2:0] SAD_SIZE_HALF = 3'h1;
    localparam logic [2:0] SAD_SIZE_WORD = 3'h2;

endpackage

/* File: core/sad_region_match.sv */
`timescale 1ns/1ps
`default_nettype none
module sad_region_match import sad_pkg::*; #(
    parameter int NREG = SAD_NREG
) (
    input wire logic [SAD_AW-1:0] addr,
    output logic [NREG-1:0] hit
);
    // Pure compare; one comparator pair per region
    for (genvar i = 0; i < NREG; i++) begin : g_reg
        assign hit[i] = (addr >= SAD_BASE[i]) && (addr <= SAD_LIMIT[i]);
    end
endmodule // sad_region_match
`default_nettype wire

/* File: core/sad_width_check.sv */
`timescale 1ns/1ps
`default_nettype none
module sad_width_check import sad_pkg::*; (
    input wire logic [2:0] size,
    input wire logic in_clock_reset_ctrl,
    input wire logic in_power_ctrl,
    output logic width_ok
);
    always_comb begin
        if (size > SAD_SIZE_WORD) begin
            width_ok = 1'b0;
        end else if (in_clock_reset_ctrl) begin
            width_ok = 1'b1;
        end else if (in_power_ctrl) begin
            width_ok = (size != SAD_SIZE_BYTE);
        end else begin
            width_ok = 1'b1;
        end
    end
endmodule // sad_width_check
`default_nettype wire

/* File: bench/sad_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
module sad_bus_master import sad_pkg::*; (
    input wire logic clk_sys,
    output logic req_valid,
    output logic [SAD_AW-1:0] req_addr,
    output logic [2:0] req_size,
    output logic req_write
);
    initial begin
        req_valid = 1'b0;
        req_addr = 32'h0;
        req_size = SAD_SIZE_WORD;
        req_write = 1'b0;
    end

    // Called just after a falling edge; request is taken at the next rise
    task automatic drive(input logic [SAD_AW-1:0] a, input logic [2:0] s,
                         input logic w);
        req_valid = 1'b1;
        req_addr = a;
        req_size = s;
        req_write = w;
        @(negedge clk_sys);
    endtask

    // Idle bus shows junk so a stale address cannot pass for a live one
    task automatic release_bus();
        req_valid = 1'b0;
        req_addr = ~req_addr;
        req_write = ~req_write;
        @(negedge clk_sys);
    endtask
endmodule // sad_bus_master
`default_nettype wire

/* File: bench/test_system_address_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_system_address_decoder import sad_pkg::*;;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] boot_sel = SAD_BOOT_FLASH;
    logic sram_cfg_8k = 1'b0;
    logic req_valid, req_write;
    logic [SAD_AW-1:0] req_addr;
    logic [2:0] req_size;
    logic dec_valid_reg, wr_en_reg, zero_rdata_reg, err_resp_reg;
    logic hard_fault_reg;
    logic [SAD_NSEL-1:0] sel_reg;
    logic [SAD_WINW-1:0] win_reg;
    int error_cnt = 0;
    int num_checks = 0;

    always #10 clk_sys = ~clk_sys;

    sad_bus_master sad_bus_master_inst (.clk_sys(clk_sys),
        .req_valid(req_valid), .req_addr(req_addr), .req_size(req_size),
        .req_write(req_write));

    sad_decoder sad_decoder_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .req_valid(req_valid), .req_addr(req_addr), .req_size(req_size),
        .req_write(req_write), .boot_sel(boot_sel),
        .sram_cfg_8k(sram_cfg_8k), .dec_valid_reg(dec_valid_reg),
        .sel_reg(sel_reg), .win_reg(win_reg), .wr_en_reg(wr_en_reg),
        .zero_rdata_reg(zero_rdata_reg), .err_resp_reg(err_resp_reg),
        .hard_fault_reg(hard_fault_reg));

    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Select bit sb below zero means the access must be refused
    task automatic acc(input logic [31:0] a, input logic [2:0] s,
                       input logic w, input int sb, input logic [6:0] win);
        logic ok;
        ok = (sb >= 0);
        sad_bus_master_inst.drive(a, s, w);
        chk("dec_valid", dec_valid_reg, 1'b1);
        chk("sel", sel_reg, ok ? (10'h001 << sb) : 10'h000);
        chk("win", win_reg, ok ? win : 7'h00);
        chk("wr_en", wr_en_reg, ok & w);
        chk("zero_rdata", zero_rdata_reg, !ok & !w);
        chk("err", err_resp_reg, !ok);
        chk("fault", hard_fault_reg, !ok & (a >= SAD_PERIPH_SPACE));
    endtask

    task automatic idle();
        sad_bus_master_inst.release_bus();
        chk("idle_valid", dec_valid_reg, 1'b0);
        chk("idle_err", err_resp_reg, 1'b0);
    endtask

    task automatic t_alias();
        int tgt [4];
        tgt = '{SAD_S_FLASH, SAD_S_SYSMEM, SAD_S_SRAM, SAD_S_FLASH};
        for (int b = 0; b < 4; b++) begin
            boot_sel = b[1:0];
            acc(32'h0001_FFFC, SAD_SIZE_WORD, 1'b0, tgt[b], 7'h00);
        end
        idle();
        $display("t_alias done");
    endtask

    task automatic t_mem();
        acc(32'h0800_0000, SAD_SIZE_WORD, 1'b1, SAD_S_FLASH, 7'h00);
        acc(32'h1FFF_0000, SAD_SIZE_WORD, 1'b0, SAD_S_SYSMEM, 7'h00);
        acc(32'h1FFF_2FFC, SAD_SIZE_WORD, 1'b0, SAD_S_SYSMEM, 7'h00);
        acc(32'h1FFF_3000, SAD_SIZE_WORD, 1'b0, SAD_S_UID, 7'h00);
        acc(32'h1FFF_3080, SAD_SIZE_WORD, 1'b0, SAD_S_OPTION, 7'h00);
        acc(32'h2000_3FFC, SAD_SIZE_WORD, 1'b1, SAD_S_SRAM, 7'h00);
        acc(32'h1FFF_3400, SAD_SIZE_WORD, 1'b1, -1, 7'h00);
        acc(32'h2000_4000, SAD_SIZE_WORD, 1'b0, -1, 7'h00);
        acc(32'h0002_0000, SAD_SIZE_WORD, 1'b0, -1, 7'h00);
        idle();
        $display("t_mem done");
    endtask

    task automatic t_periph();
        acc(32'h5000_0000, SAD_SIZE_WORD, 1'b1, SAD_S_IOP, 7'h00);
        acc(32'h5000_0800, SAD_SIZE_WORD, 1'b1, SAD_S_IOP, 7'h02);
        acc(32'h5000_1400, SAD_SIZE_WORD, 1'b0, SAD_S_IOP, 7'h05);
        acc(32'h5000_0C00, SAD_SIZE_WORD, 1'b0, -1, 7'h00);
        acc(32'h5000_1000, SAD_SIZE_WORD, 1'b1, -1, 7'h00);
        acc(32'h4002_0400, SAD_SIZE_WORD, 1'b0, -1, 7'h00);
        acc(32'h4002_0000, SAD_SIZE_WORD, 1'b0, SAD_S_HBUS, 7'h00);
        acc(32'h4002_3800, SAD_SIZE_WORD, 1'b1, SAD_S_HBUS, 7'h0E);
        acc(32'h4002_2400, SAD_SIZE_WORD, 1'b1, -1, 7'h00);
        acc(32'h4000_0000, SAD_SIZE_WORD, 1'b1, SAD_S_PBUS, 7'h00);
        acc(32'h4000_1800, SAD_SIZE_WORD, 1'b0, -1, 7'h00);
        acc(32'h4001_FFFC, SAD_SIZE_WORD, 1'b1, -1, 7'h00);
        idle();
        $display("t_periph done");
    endtask

    task automatic t_width();
        acc(32'h4002_1003, SAD_SIZE_BYTE, 1'b1, SAD_S_HBUS, 7'h04);
        acc(32'h4002_1002, SAD_SIZE_HALF, 1'b0, SAD_S_HBUS, 7'h04);
        acc(32'h4000_7002, SAD_SIZE_HALF, 1'b1, SAD_S_PBUS, 7'h1C);
        acc(32'h4000_7001, SAD_SIZE_BYTE, 1'b0, -1, 7'h00);
        acc(32'h4000_7000, SAD_SIZE_BYTE, 1'b1, -1, 7'h00);
        acc(32'h0800_0000, 3'h3, 1'b0, -1, 7'h00);
        idle();
        $display("t_width done");
    endtask

    // Strap is captured at the first edge after release, so wait past it
    task automatic t_sram8k();
        rst_b = 1'b0;
        sram_cfg_8k = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        acc(32'h2000_1FFC, SAD_SIZE_WORD, 1'b1, SAD_S_SRAM, 7'h00);
        acc(32'h2000_2000, SAD_SIZE_WORD, 1'b0, -1, 7'h00);
        idle();
        $display("t_sram8k done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        t_alias();
        t_mem();
        t_periph();
        t_width();
        t_sram8k();
        test_done();
    end

    // Whole run is under a hundred cycles; this bound is far past it
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule // test_system_address_decoder
`default_nettype wire
